// ===== psyn_cfg.svh
// Purpose: Field positions, encodings and reset values of the programming latches.
// Assumes: A 24-bit serial word whose two lowest bits address the latch.
// Notes:   Definitions only; included by every design file of the block.
`ifndef PSYN_CFG_SVH
`define PSYN_CFG_SVH

// ==========================================================
// Serial word framing
`define PSYN_WORD_W      24
`define PSYN_PIN_W       3
`define PSYN_ADDR_HI     1
`define PSYN_ADDR_LO     0
`define PSYN_ADDR_CTRL   2'h0
`define PSYN_ADDR_REF    2'h1
`define PSYN_ADDR_FB     2'h2
`define PSYN_PIN_SCLK    0
`define PSYN_PIN_DATA    1
`define PSYN_PIN_LOAD    2

// ==========================================================
// Control latch fields
`define PSYN_C_PWR_LO    2
`define PSYN_C_PWR_HI    3
`define PSYN_C_CNT_RST   4
`define PSYN_C_MUX_LO    5
`define PSYN_C_MUX_HI    7
`define PSYN_C_POLARITY  8
`define PSYN_C_PUMP_TRI  9
`define PSYN_C_GAIN      10
`define PSYN_C_PRESC_LO  22
`define PSYN_C_PRESC_HI  23

// ==========================================================
// Feedback divider latch fields
`define PSYN_N_A_LO      2
`define PSYN_N_A_HI      6
`define PSYN_N_B_LO      8
`define PSYN_N_B_HI      20
`define PSYN_N_GAIN      21
`define PSYN_N_HALVE     22
`define PSYN_N_PRESC_SRC 23

// ==========================================================
// Reference divider latch fields
`define PSYN_R_CNT_LO    2
`define PSYN_R_CNT_HI    15
`define PSYN_R_BKL_LO    16
`define PSYN_R_BKL_HI    17
`define PSYN_R_LOCK_SEL  18
`define PSYN_R_TEST_EN   19
`define PSYN_R_BAND_LO   20
`define PSYN_R_BAND_HI   21

// ==========================================================
// Encodings and reset values
`define PSYN_LOCK_FINE   3'h5
`define PSYN_LOCK_COARSE 3'h3
`define PSYN_MOD_8       18'h00008
`define PSYN_MOD_16      18'h00010
`define PSYN_MOD_32      18'h00020
`define PSYN_PRESC_8     2'h0
`define PSYN_PRESC_16    2'h1
`define PSYN_WORD_RST    24'h000000
`define PSYN_RATIO_RST   18'h00000
`define PSYN_FB_RATIO_W  18

`endif

// ===== psyn_pkg.sv
// Purpose: Types shared by the programming latch block.
// Assumes: psyn_cfg.svh supplies the numeric definitions.
// Notes:   Only types live here.
`include "psyn_cfg.svh"

package psyn_pkg;
   // Serial word as shifted in and as held in each latch.
   typedef logic [`PSYN_WORD_W-1:0] psyn_word_t;
   // Destination of a latched word.
   typedef enum logic [1:0] {
      LATCH_CTRL,
      LATCH_REF,
      LATCH_FB,
      LATCH_TEST
   } psyn_latch_t;
endpackage

// ===== psyn_pin_sync.sv
// Purpose: Two-flop synchronisers and rise detection for the serial pins.
// Assumes: Pins are asynchronous to clk; the serial clock is far slower than clk.
// Notes:   The first flop of each chain feeds only the second flop.
`timescale 1ns/1ps
`default_nettype none
`include "psyn_cfg.svh"

module psyn_pin_sync (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic [`PSYN_PIN_W-1:0] pinIn,
   output logic      [`PSYN_PIN_W-1:0] pinLevel,
   output logic      [`PSYN_PIN_W-1:0] pinRise
);
   // ==========================================================
   // Per pin chain
   genvar i;
   generate
      for (i = 0; i < `PSYN_PIN_W; i = i + 1) begin : g_pin
         logic meta_r;   // First stage, read only by the second.
         logic sync_r;   // Second stage, safe to use.
         logic last_r;   // Previous safe value for edge finding.
         // Shift the pin through the chain every clock.
         always_ff @(posedge clk) begin
            if (rst) begin
               meta_r <= 1'b0;
               sync_r <= 1'b0;
               last_r <= 1'b0;
            end else begin
               meta_r <= pinIn[i];
               sync_r <= meta_r;
               last_r <= sync_r;
            end
         end
         assign pinLevel[i] = sync_r;
         assign pinRise[i]  = sync_r & ~last_r;
      end
   endgenerate
endmodule
`default_nettype wire

// ===== psyn_program_latches.sv
// Purpose: Serial programming latches of an integer-N frequency synthesizer.
// Assumes: clk at 25 MHz samples serialClk, serialData and latchLoadStrobe.
// Notes:   Latches are write-only; every field leaves the block as an output.
`timescale 1ns/1ps
`default_nettype none
`include "psyn_cfg.svh"

module psyn_program_latches
   import psyn_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        serialClk,
   input  wire logic        serialData,
   input  wire logic        latchLoadStrobe,
   output logic             pumpThreeState,
   output logic             detectorPolarity,
   output logic [2:0]       outmuxSel,
   output logic             counterReset,
   output logic [1:0]       corePower,
   output logic [1:0]       prescalerSel,
   output logic [4:0]       aCount,
   output logic [12:0]      bCount,
   output logic             pumpGainFlag,
   output logic             outputHalveEnable,
   output logic             prescalerSourceHalved,
   output logic [17:0]      feedbackRatio,
   output logic [13:0]      refCount,
   output logic [1:0]       backlashWidth,
   output logic             lockCountSelect,
   output logic [2:0]       lockCycles,
   output logic             factoryTestEnable,
   output logic [1:0]       bandClockDiv,
   output psyn_pkg::psyn_word_t testLatchWord
);
   import psyn_pkg::*;

   // ==========================================================
   // Pin synchronisation
   // ==========================================================
   // All three serial pins come from the host's domain, so each passes
   // two flops before anything here looks at it.
   logic [`PSYN_PIN_W-1:0] pinLevel;   // Synchronised pin levels.
   logic [`PSYN_PIN_W-1:0] pinRise;    // One-cycle rise pulses.
   logic [`PSYN_PIN_W-1:0] pinIn;      // Pins gathered into a bus.

   assign pinIn = {latchLoadStrobe, serialData, serialClk};

   psyn_pin_sync u_sync (
      .clk      (clk),
      .rst      (rst),
      .pinIn    (pinIn),
      .pinLevel (pinLevel),
      .pinRise  (pinRise)
   );

   logic sclkRise;   // Serial clock rose this cycle.
   logic dataBit;    // Data level aligned with the clock samples.
   logic loadRise;   // Load strobe rose this cycle.

   assign sclkRise = pinRise[`PSYN_PIN_SCLK];
   assign dataBit  = pinLevel[`PSYN_PIN_DATA];
   assign loadRise = pinRise[`PSYN_PIN_LOAD];

   // ==========================================================
   // Input shift register
   // ==========================================================
   // The data pin goes through the same two-flop delay as the clock, so the
   // level seen at the detected rise is the one the host set up before it.
   // Only the last 24 bits are kept; extra leading bits fall off the top.
   psyn_word_t shiftWord_r;   // Word being assembled, MSB first.

   always_ff @(posedge clk) begin
      if (rst) begin
         shiftWord_r <= `PSYN_WORD_RST;
      end else if (sclkRise) begin
         shiftWord_r <= {shiftWord_r[`PSYN_WORD_W-2:0], dataBit};
      end
   end

   // ==========================================================
   // Latch address decode
   // ==========================================================
   // The two lowest bits of the shifted word name the target latch.
   psyn_latch_t target;   // Latch addressed by the current word.

   always_comb begin
      if (shiftWord_r[`PSYN_ADDR_HI:`PSYN_ADDR_LO] == `PSYN_ADDR_CTRL) begin
         target = LATCH_CTRL;
      end else if (shiftWord_r[`PSYN_ADDR_HI:`PSYN_ADDR_LO] == `PSYN_ADDR_REF) begin
         target = LATCH_REF;
      end else if (shiftWord_r[`PSYN_ADDR_HI:`PSYN_ADDR_LO] == `PSYN_ADDR_FB) begin
         target = LATCH_FB;
      end else begin
         target = LATCH_TEST;
      end
   end

   logic loadCtrl;   // Transfer into the control latch.
   logic loadRef;    // Transfer into the reference divider latch.
   logic loadFb;     // Transfer into the feedback divider latch.
   logic loadTest;   // Transfer into the test latch.

   // A strobe rise moves the word only into the latch it addresses.
   assign loadCtrl = loadRise && (target == LATCH_CTRL);
   assign loadRef  = loadRise && (target == LATCH_REF);
   assign loadFb   = loadRise && (target == LATCH_FB);
   assign loadTest = loadRise && (target == LATCH_TEST);

   // ==========================================================
   // Latches
   // ==========================================================
   // Each latch has its own process; a load for one never touches the
   // others, which keeps untargeted settings steady across writes.
   psyn_word_t synth_control_word_r;     // Control latch.
   psyn_word_t feedback_divider_word_r;  // Feedback divider latch.
   psyn_word_t reference_divider_word_r; // Reference divider latch.
   psyn_word_t testWord_r;               // Test latch, factory use only.

   // Control latch load.
   always_ff @(posedge clk) begin
      if (rst) begin
         synth_control_word_r <= `PSYN_WORD_RST;
      end else if (loadCtrl) begin
         synth_control_word_r <= shiftWord_r;
      end
   end

   // Feedback divider latch load.
   always_ff @(posedge clk) begin
      if (rst) begin
         feedback_divider_word_r <= `PSYN_WORD_RST;
      end else if (loadFb) begin
         feedback_divider_word_r <= shiftWord_r;
      end
   end

   // Reference divider latch load.
   always_ff @(posedge clk) begin
      if (rst) begin
         reference_divider_word_r <= `PSYN_WORD_RST;
      end else if (loadRef) begin
         reference_divider_word_r <= shiftWord_r;
      end
   end

   // Test latch load; held but without effect unless the test bit was set the clock before.
   always_ff @(posedge clk) begin
      if (rst) begin
         testWord_r <= `PSYN_WORD_RST;
      end else if (loadTest) begin
         testWord_r <= shiftWord_r;
      end
   end

   // ==========================================================
   // Shared charge pump gain
   // ==========================================================
   // Two latches carry the same gain bit.  Loads are one word at a time, so
   // the two sources never collide; the latest write always wins.
   logic pumpGain_r;   // One picks current setting 2, zero setting 1.

   always_ff @(posedge clk) begin
      if (rst) begin
         pumpGain_r <= 1'b0;
      end else if (loadFb) begin
         pumpGain_r <= shiftWord_r[`PSYN_N_GAIN];
      end else if (loadCtrl) begin
         pumpGain_r <= shiftWord_r[`PSYN_C_GAIN];
      end
   end

   // ==========================================================
   // Lock detect count and test gating
   // ==========================================================
   // The lock window length is registered straight from the load so that it
   // never lags the select bit.
   logic [2:0] lockCycles_r;   // Good reference cycles required for lock.
   psyn_word_t testOut_r;      // Test latch as seen by the core.

   always_ff @(posedge clk) begin
      if (rst) begin
         lockCycles_r <= `PSYN_LOCK_COARSE;
      end else if (loadRef) begin
         if (shiftWord_r[`PSYN_R_LOCK_SEL]) begin
            lockCycles_r <= `PSYN_LOCK_FINE;
         end else begin
            lockCycles_r <= `PSYN_LOCK_COARSE;
         end
      end
   end

   // The test latch reaches the core only while the test bit was set the clock before.
   always_ff @(posedge clk) begin
      if (rst) begin
         testOut_r <= `PSYN_WORD_RST;
      end else if (reference_divider_word_r[`PSYN_R_TEST_EN]) begin
         testOut_r <= testWord_r;
      end else begin
         testOut_r <= `PSYN_WORD_RST;
      end
   end

   // ==========================================================
   // Feedback ratio
   // ==========================================================
   // P times B plus A, recomputed every cycle from the held fields.  It
   // trails a latch load by one clock, far below any loop response time.
   logic [17:0] modulus;        // Prescaler modulus P.
   logic [17:0] feedbackRatio_r; // Overall feedback divide value.

   always_comb begin
      if (prescalerSel == `PSYN_PRESC_8) begin
         modulus = `PSYN_MOD_8;
      end else if (prescalerSel == `PSYN_PRESC_16) begin
         modulus = `PSYN_MOD_16;
      end else begin
         modulus = `PSYN_MOD_32;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         feedbackRatio_r <= `PSYN_RATIO_RST;
      end else begin
         feedbackRatio_r <= `PSYN_FB_RATIO_W'(modulus * `PSYN_FB_RATIO_W'(bCount))
                            + `PSYN_FB_RATIO_W'(aCount);
      end
   end

   // ==========================================================
   // Field outputs
   // ==========================================================
   // Every output is a slice of a latch flop or a dedicated flop.
   assign pumpThreeState   = synth_control_word_r[`PSYN_C_PUMP_TRI];
   assign detectorPolarity = synth_control_word_r[`PSYN_C_POLARITY];
   assign outmuxSel        = synth_control_word_r[`PSYN_C_MUX_HI:`PSYN_C_MUX_LO];
   assign counterReset     = synth_control_word_r[`PSYN_C_CNT_RST];
   assign corePower        = synth_control_word_r[`PSYN_C_PWR_HI:`PSYN_C_PWR_LO];
   assign prescalerSel     = synth_control_word_r[`PSYN_C_PRESC_HI:`PSYN_C_PRESC_LO];
   // The reserved bit is not decoded, so a stray one has no effect.
   assign aCount           = feedback_divider_word_r[`PSYN_N_A_HI:`PSYN_N_A_LO];
   // Values below three are passed on as written; the host avoids them.
   assign bCount           = feedback_divider_word_r[`PSYN_N_B_HI:`PSYN_N_B_LO];
   assign pumpGainFlag     = pumpGain_r;
   assign outputHalveEnable     = feedback_divider_word_r[`PSYN_N_HALVE];
   assign prescalerSourceHalved = feedback_divider_word_r[`PSYN_N_PRESC_SRC];
   assign feedbackRatio    = feedbackRatio_r;
   assign refCount         = reference_divider_word_r[`PSYN_R_CNT_HI:`PSYN_R_CNT_LO];
   assign backlashWidth    = reference_divider_word_r[`PSYN_R_BKL_HI:`PSYN_R_BKL_LO];
   assign lockCountSelect  = reference_divider_word_r[`PSYN_R_LOCK_SEL];
   assign lockCycles       = lockCycles_r;
   assign factoryTestEnable = reference_divider_word_r[`PSYN_R_TEST_EN];
   // Divider setting for the band select clock taken off the reference output.
   assign bandClockDiv     = reference_divider_word_r[`PSYN_R_BAND_HI:`PSYN_R_BAND_LO];
   assign testLatchWord    = testOut_r;

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // A serial rise appends the synchronised data bit.
   property p_shiftIn;
      sclkRise |=> shiftWord_r[0] == $past(dataBit);
   endproperty
   a_shiftIn: assert property (p_shiftIn) else $error("Shift missed data bit.");

   // A control load updates pump, polarity, mux and reset fields.
   property p_ctrlLoad;
      loadCtrl |=> (pumpThreeState == $past(shiftWord_r[`PSYN_C_PUMP_TRI]))
         && (detectorPolarity == $past(shiftWord_r[`PSYN_C_POLARITY]))
         && (outmuxSel == $past(shiftWord_r[`PSYN_C_MUX_HI:`PSYN_C_MUX_LO]))
         && (counterReset == $past(shiftWord_r[`PSYN_C_CNT_RST]));
   endproperty
   a_ctrlLoad: assert property (p_ctrlLoad) else $error("Control load wrong.");

   // A feedback load updates A, B and the output halving bit.
   property p_fbLoad;
      loadFb |=> (aCount == $past(shiftWord_r[`PSYN_N_A_HI:`PSYN_N_A_LO]))
         && (bCount == $past(shiftWord_r[`PSYN_N_B_HI:`PSYN_N_B_LO]))
         && (outputHalveEnable == $past(shiftWord_r[`PSYN_N_HALVE]));
   endproperty
   a_fbLoad: assert property (p_fbLoad) else $error("Feedback load wrong.");

   // A reference load updates the reference count and backlash width.
   property p_refLoad;
      loadRef |=> (refCount == $past(shiftWord_r[`PSYN_R_CNT_HI:`PSYN_R_CNT_LO]))
         && (backlashWidth == $past(shiftWord_r[`PSYN_R_BKL_HI:`PSYN_R_BKL_LO]));
   endproperty
   a_refLoad: assert property (p_refLoad) else $error("Reference load wrong.");

   // A reference load leaves the control and feedback latches untouched.
   property p_keepOthers;
      loadRef |=> $stable(synth_control_word_r) && $stable(feedback_divider_word_r);
   endproperty
   a_keepOthers: assert property (p_keepOthers) else $error("Other latch changed.");

   // The gain flag follows a feedback load.
   property p_gainFb;
      loadFb |=> pumpGainFlag == $past(shiftWord_r[`PSYN_N_GAIN]);
   endproperty
   a_gainFb: assert property (p_gainFb) else $error("Gain missed feedback write.");

   // The gain flag follows a control load.
   property p_gainCtrl;
      loadCtrl |=> pumpGainFlag == $past(shiftWord_r[`PSYN_C_GAIN]);
   endproperty
   a_gainCtrl: assert property (p_gainCtrl) else $error("Gain missed control write.");

   // The lock window always matches the select bit.
   property p_lockCount;
      lockCycles == (lockCountSelect ? `PSYN_LOCK_FINE : `PSYN_LOCK_COARSE);
   endproperty
   a_lockCount: assert property (p_lockCount) else $error("Lock count mismatch.");

   // Two cycles after a feedback load the ratio is P times B plus A.
   property p_ratio;
      loadFb |=> ##1 feedbackRatio ==
         `PSYN_FB_RATIO_W'(modulus * `PSYN_FB_RATIO_W'(bCount)) + `PSYN_FB_RATIO_W'(aCount);
   endproperty
   a_ratio: assert property (p_ratio) else $error("Feedback ratio wrong.");

   // With the test bit clear in two successive cycles the test latch never reaches the core.
   property p_testGate;
      !factoryTestEnable ##1 !factoryTestEnable |-> testLatchWord == `PSYN_WORD_RST;
   endproperty
   a_testGate: assert property (p_testGate) else $error("Test latch leaked.");

   property p_covCtrl;
      loadCtrl;
   endproperty
   c_covCtrl: cover property (p_covCtrl);

   property p_covFb;
      loadFb;
   endproperty
   c_covFb: cover property (p_covFb);

   property p_covRef;
      loadRef ##[1:1000] loadCtrl;
   endproperty
   c_covRef: cover property (p_covRef);

   property p_covGainFlip;
      loadFb ##[1:1000] (loadCtrl && (shiftWord_r[`PSYN_C_GAIN] != pumpGainFlag));
   endproperty
   c_covGainFlip: cover property (p_covGainFlip);
endmodule
`default_nettype wire

// ===== psyn_host_model.sv
// Purpose: Host model that writes 24-bit words into the latches over the three-wire link.
// Assumes: Called just after a rising clk edge; one serial clock period is 8 clk (320 ns).
// Notes:   Serial clock idles low between frames; data shows a changed level when released.
`timescale 1ns/1ps
`default_nettype none
`include "psyn_cfg.svh"

module psyn_host_model (
   input  wire logic clk,
   output logic      serialClk,
   output logic      serialData,
   output logic      latchLoadStrobe
);
   import psyn_pkg::*;

   // ==========================================================
   // Idle levels
   initial begin
      serialClk = 1'b0;
      serialData = 1'b0;
      latchLoadStrobe = 1'b0;
   end

   // ==========================================================
   // Word transfer
   // Data settles 4 clk before each serial rise and holds 4 clk after it.
   task automatic send(input psyn_word_t w);
      for (int i = `PSYN_WORD_W - 1; i >= 0; i--) begin
         serialData <= w[i];
         repeat (4) @(posedge clk);
         serialClk <= 1'b1;
         repeat (4) @(posedge clk);
         serialClk <= 1'b0;
      end
      // Released data no longer shows the last bit.
      serialData <= ~w[0];
      repeat (4) @(posedge clk);
      latchLoadStrobe <= 1'b1;
      repeat (8) @(posedge clk);
      latchLoadStrobe <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ===== psyn_program_latches_tb.sv
// Purpose: Self-checking bench for the serial programming latches.
// Assumes: The host model drives the pins; a reference model predicts every output.
// Notes:   All outputs are compared as one vector after each latched word.
`timescale 1ns/1ps
`default_nettype none
`include "psyn_cfg.svh"

module psyn_program_latches_tb;
   import psyn_pkg::*;

   // ==========================================================
   // Signals
   logic        clk, rst, serialClk, serialData, latchLoadStrobe;
   logic        pumpThreeState, detectorPolarity, counterReset, pumpGainFlag;
   logic        outputHalveEnable, prescalerSourceHalved, lockCountSelect, factoryTestEnable;
   logic [2:0]  outmuxSel, lockCycles;
   logic [1:0]  corePower, prescalerSel, backlashWidth, bandClockDiv;
   logic [4:0]  aCount;
   logic [12:0] bCount;
   logic [17:0] feedbackRatio;
   logic [13:0] refCount;
   psyn_word_t  testLatchWord, ctrlW, fbW, refW, testW;
   logic        gainR;
   logic [95:0] seen;
   logic [95:0] expQ[$];
   int          seed, mismatches, nTests;
   event        chk;

   // The whole output set seen as one vector.
   assign seen = {pumpThreeState, detectorPolarity, outmuxSel, counterReset, corePower,
                  prescalerSel, aCount, bCount, pumpGainFlag, outputHalveEnable,
                  prescalerSourceHalved, feedbackRatio, refCount, backlashWidth,
                  lockCountSelect, lockCycles, factoryTestEnable, bandClockDiv, testLatchWord};

   psyn_program_latches u_dut (.clk(clk), .rst(rst), .serialClk(serialClk),
      .serialData(serialData), .latchLoadStrobe(latchLoadStrobe),
      .pumpThreeState(pumpThreeState), .detectorPolarity(detectorPolarity),
      .outmuxSel(outmuxSel), .counterReset(counterReset), .corePower(corePower),
      .prescalerSel(prescalerSel), .aCount(aCount), .bCount(bCount),
      .pumpGainFlag(pumpGainFlag), .outputHalveEnable(outputHalveEnable),
      .prescalerSourceHalved(prescalerSourceHalved), .feedbackRatio(feedbackRatio),
      .refCount(refCount), .backlashWidth(backlashWidth), .lockCountSelect(lockCountSelect),
      .lockCycles(lockCycles), .factoryTestEnable(factoryTestEnable),
      .bandClockDiv(bandClockDiv), .testLatchWord(testLatchWord));

   psyn_host_model u_host (.clk(clk), .serialClk(serialClk), .serialData(serialData),
      .latchLoadStrobe(latchLoadStrobe));

   // ==========================================================
   // Reference model
   // Predicts every output from the words written so far.
   function automatic logic [95:0] expect_vec();
      logic [17:0] p;
      p = (ctrlW[23:22] == 2'h0) ? 18'h00008 : (ctrlW[23:22] == 2'h1) ? 18'h00010 : 18'h00020;
      return {ctrlW[9], ctrlW[8], ctrlW[7:5], ctrlW[4], ctrlW[3:2], ctrlW[23:22], fbW[6:2],
              fbW[20:8], gainR, fbW[22], fbW[23], 18'(p * fbW[20:8] + fbW[6:2]), refW[15:2],
              refW[17:16], refW[18], (refW[18] ? 3'h5 : 3'h3), refW[19], refW[21:20],
              (refW[19] ? testW : 24'h000000)};
   endfunction

   // Random word for one latch, with unused feedback and reference bits and the test bit zero, and B at least 4.
   function automatic psyn_word_t rnd(input logic [1:0] a);
      psyn_word_t w;
      w = psyn_word_t'($random(seed));
      if (a == 2'h1) w = (w & 24'h37FFFC) | 24'h000001;
      if (a == 2'h2) w = (w & 24'hFFFF7C) | 24'h000402;
      if (a == 2'h0) w = w & 24'hFFFFFC;
      // The test latch is reached only through address three.
      if (a == 2'h3) w = w | 24'h000003;
      return w;
   endfunction

   // Writes one word, updates the model and queues the expected outputs.
   task automatic wr(input psyn_word_t w);
      u_host.send(w);
      if (w[1:0] == 2'h0) ctrlW = w;
      if (w[1:0] == 2'h1) refW = w;
      if (w[1:0] == 2'h2) fbW = w;
      if (w[1:0] == 2'h3) testW = w;
      if (w[1:0] == 2'h0) gainR = w[10];
      if (w[1:0] == 2'h2) gainR = w[21];
      expQ.push_back(expect_vec());
      ->chk;
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", nTests, mismatches);
      if (mismatches == 0 && nTests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // ==========================================================
   // Clock, watchdog and output monitor
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // A hang long past the expected run counts as a failure.
   initial begin
      repeat (30000) @(posedge clk);
      mismatches++;
      stop_test();
   end

   // Takes the oldest expectation whenever a word has been latched.
   initial begin
      logic [95:0] e;
      forever begin
         @(chk);
         #1;
         e = expQ.pop_front();
         nTests++;
         if (seen !== e) begin
            mismatches++;
            $display("wrong value outputs expected %h seen %h", e, seen);
         end
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      rst = 1'b1;
      seed = 56;
      mismatches = 0;
      nTests = 0;
      {ctrlW, fbW, refW, testW, gainR} = '0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      expQ.push_back(expect_vec());
      ->chk;
      wr(rnd(2'h1));
      wr(rnd(2'h0));
      wr(rnd(2'h2));
      // Every prescaler code against a fresh divider word.
      for (int i = 0; i < 4; i++) begin
         wr((rnd(2'h0) & 24'h3FFFFF) | psyn_word_t'(i << 22));
         wr(rnd(2'h2));
      end
      wr(24'h1FFF7E);
      wr(24'h000302);
      wr(24'h00FFFD);
      wr(24'h040005);
      wr(24'h000400);
      wr(24'h200402);
      wr(24'h000000);
      wr(rnd(2'h3));
      wr(24'h080005);
      wr(24'h000005);
      // Mixed random traffic checks that other latches stay put.
      repeat (16) wr(rnd(2'($unsigned($random(seed)) % 3)));
      repeat (4) @(posedge clk);
      stop_test();
   end
endmodule
`default_nettype wire
